// file: rtl/port_pin_mode_logic.sv
// port pin mode logic: direction, data in/out, logic-array pin use and
// latched address output (ports a and b only) for four 8-bit ports, with an apb register slave
// assumes logic-array terms and address strobe come from logic on pclk,
// pins come from outside and are synchronised here
//
// Function
// - direction bit one makes the pin an output, zero an input
// - all direction registers clear to zero at reset
// - ports a-c reach array bus via input cells; port d goes direct
// - ports a-c driven by general array; port d by decode array
// - a pin used as array output ignores register i/o and address mode
// - data-in still returns a pin's level when it feeds the array
// - direction bit still acts on a pin used as array input
// - data-out writes do not change an array output pin's value
// - output enable is array enable term or direction bit
// - an enable term true at reset drives the pin despite direction zero
// - an internal-only array output leaves its pin free for other uses
// - address taken from the muxed bus by strobe and driven on pins
// - address output is chosen per pin on the first two ports
// - select bit one gives address output, zero gives register i/o
// - port a bit n gives An; port b gives An or A(n+8)
// - port a address select clears to zero at reset
// - data-in bit reads one for a high pin, zero for low
// - data-out bit sets the driven level of an output pin
// - direction may change at any time; ports may mix directions
`timescale 1ns/10ps
module port_pin_mode_logic (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic addr_strobe,
  input wire logic [15:0] mux_addr_data,
  input wire logic [7:0] addr_high_byte_sel,
  input wire logic [31:0] array_out_sel,
  input wire logic [31:0] array_out_val,
  input wire logic [31:0] array_oe_term,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic [31:0] logic_array_in
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] dir;
    logic [31:0] dout;
    logic [7:0] asel_a;
    logic [7:0] asel_b;
    logic [31:0] rdata;
    logic err;
  } ppml_state_s;

  ppml_state_s st;
  ppml_state_s next_st;

  // ********************************************************
  // address decode
  // ********************************************************
  // returns {hit, index}; misaligned or unmapped addresses miss
  function automatic logic [6:0] ppml_decode(input logic [7:0] a);
    logic [5:0] idx;
    logic hit;
    idx = a[7:2];
    hit = 1'b0;
    if (a[1:0] == 2'b00) begin
      unique case (idx)
        ppml_pkg::IDX_A_DATA_IN, ppml_pkg::IDX_B_DATA_IN,
        ppml_pkg::IDX_A_ADDR_SEL, ppml_pkg::IDX_B_ADDR_SEL,
        ppml_pkg::IDX_A_DATA_OUT, ppml_pkg::IDX_B_DATA_OUT,
        ppml_pkg::IDX_A_DIR, ppml_pkg::IDX_B_DIR,
        ppml_pkg::IDX_C_DATA_IN, ppml_pkg::IDX_D_DATA_IN,
        ppml_pkg::IDX_C_DATA_OUT, ppml_pkg::IDX_D_DATA_OUT,
        ppml_pkg::IDX_C_DIR, ppml_pkg::IDX_D_DIR: begin
          hit = 1'b1;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
    return {hit, idx};
  endfunction

  // byte lane of one port out of a 32-pin vector
  function automatic logic [7:0] ppml_port(input logic [31:0] v, input int lsb);
    return v[lsb +: 8];
  endfunction

  // read value of one mapped register; unimplemented bits come back as zero
  // data-in sees the synchronised pin, so a pin in array use still reads back
  function automatic logic [7:0] ppml_read_reg(
    input logic [5:0] idx,
    input logic [31:0] lvl,
    input ppml_state_s s
  );
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      ppml_pkg::IDX_A_DATA_IN: begin
        r = ppml_port(lvl, ppml_pkg::PORT_A_LSB);
      end
      ppml_pkg::IDX_B_DATA_IN: begin
        r = ppml_port(lvl, ppml_pkg::PORT_B_LSB);
      end
      ppml_pkg::IDX_C_DATA_IN: begin
        r = ppml_port(lvl, ppml_pkg::PORT_C_LSB);
      end
      ppml_pkg::IDX_D_DATA_IN: begin
        r = ppml_port(lvl, ppml_pkg::PORT_D_LSB);
      end
      ppml_pkg::IDX_A_ADDR_SEL: begin
        r = s.asel_a;
      end
      ppml_pkg::IDX_B_ADDR_SEL: begin
        r = s.asel_b;
      end
      ppml_pkg::IDX_A_DATA_OUT: begin
        r = ppml_port(s.dout, ppml_pkg::PORT_A_LSB);
      end
      ppml_pkg::IDX_B_DATA_OUT: begin
        r = ppml_port(s.dout, ppml_pkg::PORT_B_LSB);
      end
      ppml_pkg::IDX_C_DATA_OUT: begin
        r = ppml_port(s.dout, ppml_pkg::PORT_C_LSB);
      end
      ppml_pkg::IDX_D_DATA_OUT: begin
        r = ppml_port(s.dout, ppml_pkg::PORT_D_LSB);
      end
      ppml_pkg::IDX_A_DIR: begin
        r = ppml_port(s.dir, ppml_pkg::PORT_A_LSB);
      end
      ppml_pkg::IDX_B_DIR: begin
        r = ppml_port(s.dir, ppml_pkg::PORT_B_LSB);
      end
      ppml_pkg::IDX_C_DIR: begin
        r = ppml_port(s.dir, ppml_pkg::PORT_C_LSB);
      end
      ppml_pkg::IDX_D_DIR: begin
        r = ppml_port(s.dir, ppml_pkg::PORT_D_LSB);
      end
      default: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction

  // pin drive priority: array output, then latched address, then data-out
  // a pin claimed by the array ignores data-out, so stray writes cannot glitch it
  function automatic logic ppml_drive(
    input logic arr_sel,
    input logic arr_val,
    input logic adr_sel,
    input logic adr_val,
    input logic reg_val
  );
    logic v;
    if (arr_sel) begin
      v = arr_val;
    end else if (adr_sel) begin
      v = adr_val;
    end else begin
      v = reg_val;
    end
    return v;
  endfunction

  // one pin's enable; an unimplemented pin never drives, whatever the term
  function automatic logic ppml_enable(
    input logic implemented,
    input logic term,
    input logic dir_bit
  );
    return implemented & (term | dir_bit);
  endfunction

  logic [6:0] dec;
  logic setup_phase;
  logic access_wr;
  logic [31:0] pin_level;

  assign dec = ppml_decode(paddr);
  assign setup_phase = psel && !penable;
  assign access_wr = psel && penable && pwrite && dec[6];
  // data-in reads the synchronised pin, not the array path
  assign pin_level = st.sync2 & ppml_pkg::PIN_MASK;

  // ********************************************************
  // register file and synchronisers
  // ********************************************************
  always_comb begin
    next_st = st;
    // pins are asynchronous: two flops before any reader
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;

    // read data and error caught in the setup cycle, so access ends at once
    if (setup_phase) begin
      next_st.err = !dec[6];
      next_st.rdata = 32'h0000_0000;
      if (dec[6] && !pwrite) begin
        next_st.rdata[7:0] = ppml_read_reg(dec[5:0], pin_level, st);
      end
    end

    // writes land only at the access edge; direction may change any time
    if (access_wr) begin
      unique case (dec[5:0])
        ppml_pkg::IDX_A_ADDR_SEL: begin
          next_st.asel_a = pwdata[7:0];
        end
        ppml_pkg::IDX_B_ADDR_SEL: begin
          next_st.asel_b = pwdata[7:0];
        end
        ppml_pkg::IDX_A_DATA_OUT: begin
          next_st.dout[7:0] = pwdata[7:0] & ppml_pkg::PORT_A_MASK;
        end
        ppml_pkg::IDX_B_DATA_OUT: begin
          next_st.dout[15:8] = pwdata[7:0] & ppml_pkg::PORT_B_MASK;
        end
        ppml_pkg::IDX_C_DATA_OUT: begin
          next_st.dout[23:16] = pwdata[7:0] & ppml_pkg::PORT_C_MASK;
        end
        ppml_pkg::IDX_D_DATA_OUT: begin
          next_st.dout[31:24] = pwdata[7:0] & ppml_pkg::PORT_D_MASK;
        end
        ppml_pkg::IDX_A_DIR: begin
          next_st.dir[7:0] = pwdata[7:0] & ppml_pkg::PORT_A_MASK;
        end
        ppml_pkg::IDX_B_DIR: begin
          next_st.dir[15:8] = pwdata[7:0] & ppml_pkg::PORT_B_MASK;
        end
        ppml_pkg::IDX_C_DIR: begin
          next_st.dir[23:16] = pwdata[7:0] & ppml_pkg::PORT_C_MASK;
        end
        ppml_pkg::IDX_D_DIR: begin
          next_st.dir[31:24] = pwdata[7:0] & ppml_pkg::PORT_D_MASK;
        end
        default: begin
          // data-in registers are read only: writes are dropped
          next_st.err = st.err;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.sync1 <= 32'h0000_0000;
      st.sync2 <= 32'h0000_0000;
      st.dir <= {4{ppml_pkg::DIR_RESET}};
      st.dout <= {4{ppml_pkg::DATA_OUT_RESET}};
      st.asel_a <= ppml_pkg::ADDR_SEL_RESET;
      st.asel_b <= ppml_pkg::ADDR_SEL_RESET;
      st.rdata <= 32'h0000_0000;
      st.err <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // zero wait states: data was captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.err;

  // ********************************************************
  // latched address
  // ********************************************************
  ppml_addr_if addr_bus ();

  assign addr_bus.ale = addr_strobe;
  assign addr_bus.mux_bus = mux_addr_data;

  ppml_addr_latch u_latch (
    .pclk(pclk),
    .presetn(presetn),
    .lat(addr_bus.latch)
  );

  // ********************************************************
  // logic-array input bus
  // ********************************************************
  logic [23:0] cell_q;

  ppml_input_cells u_cells (
    .pclk(pclk),
    .presetn(presetn),
    .pin_level(pin_level[23:0]),
    .cell_q(cell_q)
  );

  // ports a-c through input cells, port d direct
  assign logic_array_in = {pin_level[31:24], cell_q};

  // ********************************************************
  // per-pin output mux and enable
  // ********************************************************
  // array_out_sel low for an internal-only macrocell frees the pin
  logic [31:0] addr_sel;
  logic [31:0] addr_val;
  logic [31:0] out_sel;

  // only implemented pins may be claimed by an array output
  assign out_sel = array_out_sel & ppml_pkg::PIN_MASK;

  genvar n;
  generate
    for (n = 0; n < ppml_pkg::PORT_W; n++) begin : g_addr
      // per-pin choice on the first two ports only
      assign addr_sel[n] = st.asel_a[n];
      assign addr_val[n] = addr_bus.addr[n];
      assign addr_sel[n + 8] = st.asel_b[n];
      assign addr_val[n + 8] = addr_high_byte_sel[n] ? addr_bus.addr[n + 8] :
                               addr_bus.addr[n];
    end
    for (n = 16; n < ppml_pkg::PINS; n++) begin : g_noaddr
      assign addr_sel[n] = 1'b0;
      assign addr_val[n] = 1'b0;
    end
    for (n = 0; n < ppml_pkg::PINS; n++) begin : g_pin
      // array output wins over address and register i/o
      assign pin_out[n] = ppml_drive(out_sel[n], array_out_val[n], addr_sel[n], addr_val[n],
                                     st.dout[n]);
      // enable is a plain or; direction still acts for array inputs
      assign pin_oe[n] = ppml_enable(ppml_pkg::PIN_MASK[n], array_oe_term[n],
                                     st.dir[n]);
    end
  endgenerate

endmodule

// file: rtl/ppml_addr_if.sv
// interface between the pin logic and its address latch
// assumes both ends run on pclk; the strobe comes from core logic on pclk
`timescale 1ns/10ps
interface ppml_addr_if;
  logic ale;
  logic [15:0] mux_bus;
  logic [15:0] addr;
  modport latch (input ale, input mux_bus, output addr);
  modport user (output ale, output mux_bus, input addr);
endinterface

// file: rtl/ppml_addr_latch.sv
// address latch: demultiplexes the address from the shared address/data bus
// assumes ale and the bus come from core logic on pclk, so no synchroniser
`timescale 1ns/10ps
module ppml_addr_latch (
  input wire logic pclk,
  input wire logic presetn,
  ppml_addr_if.latch lat
);

  typedef struct packed {
    logic ale_d;
    logic [15:0] addr;
  } ppml_latch_s;

  ppml_latch_s st;
  ppml_latch_s next_st;

  always_comb begin
    next_st = st;
    next_st.ale_d = lat.ale;
    // capture on the falling strobe, hold until the next one
    if (st.ale_d && !lat.ale) begin
      next_st.addr = lat.mux_bus;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lat.addr = st.addr;

endmodule

// file: rtl/ppml_input_cells.sv
// input macrocells of the first three ports, feeding the logic-array bus
// assumes pin levels arrive already synchronised to pclk
`timescale 1ns/10ps
module ppml_input_cells (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [23:0] pin_level,
  output logic [23:0] cell_q
);

  typedef struct packed {
    logic [23:0] q;
  } ppml_cells_s;

  ppml_cells_s st;
  ppml_cells_s next_st;

  always_comb begin
    next_st = st;
    next_st.q = pin_level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cell_q = st.q;

endmodule

// file: rtl/ppml_pkg.sv
// package of register indices, masks and reset values for the port pin block
// assumes a 32-bit apb slave; each register index sits at byte address index*4
package ppml_pkg;

  // ********************************************************
  // register indices (byte address is index * 4)
  // ********************************************************
  localparam logic [5:0] IDX_A_DATA_IN = 6'h00;
  localparam logic [5:0] IDX_B_DATA_IN = 6'h01;
  localparam logic [5:0] IDX_A_ADDR_SEL = 6'h02;
  localparam logic [5:0] IDX_B_ADDR_SEL = 6'h03;
  localparam logic [5:0] IDX_A_DATA_OUT = 6'h04;
  localparam logic [5:0] IDX_B_DATA_OUT = 6'h05;
  localparam logic [5:0] IDX_A_DIR = 6'h06;
  localparam logic [5:0] IDX_B_DIR = 6'h07;
  localparam logic [5:0] IDX_C_DATA_IN = 6'h10;
  localparam logic [5:0] IDX_D_DATA_IN = 6'h11;
  localparam logic [5:0] IDX_C_DATA_OUT = 6'h12;
  localparam logic [5:0] IDX_D_DATA_OUT = 6'h13;
  localparam logic [5:0] IDX_C_DIR = 6'h14;
  localparam logic [5:0] IDX_D_DIR = 6'h15;

  // ********************************************************
  // port layout and implemented bits
  // ********************************************************
  localparam int PORT_W = 8;
  localparam int PINS = 32;
  localparam int CELL_PINS = 24;
  localparam int PORT_A_LSB = 0;
  localparam int PORT_B_LSB = 8;
  localparam int PORT_C_LSB = 16;
  localparam int PORT_D_LSB = 24;
  localparam logic [7:0] PORT_A_MASK = 8'hff;
  localparam logic [7:0] PORT_B_MASK = 8'hff;
  localparam logic [7:0] PORT_C_MASK = 8'h9c;
  localparam logic [7:0] PORT_D_MASK = 8'h06;
  localparam logic [31:0] PIN_MASK = {PORT_D_MASK, PORT_C_MASK, PORT_B_MASK, PORT_A_MASK};

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_OUT_RESET = 8'h00;
  localparam logic [7:0] ADDR_SEL_RESET = 8'h00;

endpackage

// file: testbench/port_pin_mode_logic_test.sv
// self-checking bench for the port pin block
// assumes the pin model closes the loop from pin_out back to pin_in
`timescale 1ns/10ps
module port_pin_mode_logic_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic addr_strobe = 1'b0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00, addr_high_byte_sel = 8'h00;
  logic [15:0] mux_addr_data = 16'h0000;
  logic [31:0] pwdata = 32'h0, array_out_sel = 32'h0, array_out_val = 32'h0, rd;
  logic [31:0] array_oe_term = 32'h1, ext_drive = 32'h0, ext_en = 32'h0;
  logic [31:0] prdata, pin_in, pin_out, pin_oe, logic_array_in;
  int err_total = 0, n_checks = 0;
  // rows: index, write data, read-back
  logic [21:0] rows [10] = '{{6'h02, 8'ha5, 8'ha5}, {6'h03, 8'h5a, 8'h5a}, {6'h04, 8'h3c, 8'h3c},
    {6'h05, 8'hc3, 8'hc3}, {6'h06, 8'hf0, 8'hf0}, {6'h07, 8'h0f, 8'h0f}, {6'h12, 8'hff, 8'h9c},
    {6'h13, 8'hff, 8'h06}, {6'h14, 8'hff, 8'h9c}, {6'h15, 8'hff, 8'h06}};
  logic [13:0] din [4] = '{{6'h00, 8'h3a}, {6'h01, 8'h53}, {6'h10, 8'h9c}, {6'h11, 8'h06}};
  always #25 pclk = ~pclk;
  port_pin_mode_logic dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .addr_strobe, .mux_addr_data, .addr_high_byte_sel, .array_out_sel,
    .array_out_val, .array_oe_term, .pin_in, .pin_out, .pin_oe, .logic_array_in);
  ppml_pins_model model (.pin_out, .pin_oe, .ext_drive, .ext_en, .pin_in);
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      err_total++;
    end
  endtask
  task apb(input logic w, input logic [5:0] i, input logic [7:0] d, input logic [1:0] lo);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    repeat (12) @(posedge pclk);
    chk(pin_oe, 32'h1);
    presetn <= 1'b1;
    foreach (rows[k]) begin
      apb(1'b0, rows[k][21:16], 8'h00, 2'h0);
      chk(rd, 32'h0);
    end
    foreach (rows[k]) begin
      apb(1'b1, rows[k][21:16], rows[k][15:8], 2'h0);
      apb(1'b0, rows[k][21:16], 8'h00, 2'h0);
      chk(rd, {24'h0, rows[k][7:0]});
    end
    chk({31'h0, er}, 32'h0);
    apb(1'b1, 6'h02, 8'h00, 2'h0);
    apb(1'b1, 6'h03, 8'h00, 2'h0);
    chk(pin_oe, 32'h069c0ff1);
    chk(pin_out & pin_oe, 32'h069c0330);
    @(posedge pclk);
    ext_en <= 32'hffffffff;
    ext_drive <= 32'h5a5a5a5a;
    repeat (4) @(posedge pclk);
    foreach (din[k]) begin
      // data-in takes no write; the pin level comes back
      apb(1'b1, din[k][13:8], 8'hff, 2'h0);
      apb(1'b0, din[k][13:8], 8'h00, 2'h0);
      chk(rd, {24'h0, din[k][7:0]});
    end
    chk(logic_array_in & ppml_pkg::PIN_MASK, pin_in & ppml_pkg::PIN_MASK);
    @(posedge pclk);
    array_out_sel <= 32'h0000000f;
    array_out_val <= 32'h00000005;
    apb(1'b1, 6'h04, 8'hff, 2'h0);
    chk({24'h0, pin_out[7:0]}, 32'hf5);
    apb(1'b1, 6'h02, 8'hff, 2'h0);
    apb(1'b1, 6'h03, 8'hff, 2'h0);
    @(posedge pclk);
    addr_high_byte_sel <= 8'hf0;
    addr_strobe <= 1'b1;
    mux_addr_data <= 16'hbeef;
    @(posedge pclk);
    addr_strobe <= 1'b0;
    @(posedge pclk);
    mux_addr_data <= 16'h1234;
    repeat (2) @(posedge pclk);
    #1;
    chk({16'h0, pin_out[15:0]}, 32'hbfe5);
    apb(1'b1, 6'h02, 8'h0f, 2'h0);
    chk({16'h0, pin_out[15:0]}, 32'hbff5);
    apb(1'b0, 6'h08, 8'h00, 2'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 6'h06, 8'h00, 2'h1);
    chk({31'h0, er}, 32'h1);
    @(posedge pclk);
    array_oe_term <= 32'h80000004;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(pin_oe, 32'h80000004 & ppml_pkg::PIN_MASK);
    presetn <= 1'b1;
    apb(1'b0, 6'h06, 8'h00, 2'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule

// file: testbench/ppml_chk.sv
// port-level assertions for the port pin block
// assumes one pclk domain and async active-low presetn
`timescale 1ns/10ps
module ppml_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic addr_strobe,
  input wire logic [7:0] addr_high_byte_sel,
  input wire logic [31:0] array_out_sel,
  input wire logic [31:0] array_out_val,
  input wire logic [31:0] array_oe_term,
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] logic_array_in
);
  localparam logic [31:0] pm = ppml_pkg::PIN_MASK;
  // the synchroniser holds reset values for two edges, the input cells for three
  logic [1:0] age;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_s;
    setup_s ##0 (paddr[1:0] != 2'h0) ##1 (psel && penable);
  endsequence
  sequence wr_s;
    setup_s ##0 pwrite ##1 (psel && penable && pwrite);
  endsequence
  ready_a: assert property (setup_s |=> pready)
    else $error("pready low in access phase");
  misalign_err_a: assert property (bad_s |-> pslverr)
    else $error("misaligned access not refused");
  rdata_top_a: assert property (psel && penable |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  oe_mask_a: assert property ((pin_oe & ~pm) == 32'h0)
    else $error("enable on unimplemented pin");
  oe_term_a: assert property (((array_oe_term & pm) & ~pin_oe) == 32'h0)
    else $error("enable term not driving pin");
  array_drive_a: assert property (((pin_out ^ array_out_val) & array_out_sel & pm) == 32'h0)
    else $error("array output pin not array value");
  direct_in_a: assert property (age == 2'h3 |-> (logic_array_in[31:24] & pm[31:24]) == ($past(pin_in[31:24], 2) & pm[31:24]))
    else $error("direct array input wrong");
  cell_in_a: assert property (age == 2'h3 |-> (logic_array_in[23:0] & pm[23:0]) == ($past(pin_in[23:0], 3) & pm[23:0]))
    else $error("cell array input wrong");
  oe_cause_a: assert property ($changed(pin_oe) && $stable(array_oe_term) |-> $past(psel && penable && pwrite))
    else $error("enable changed with no write");
  out_cause_a: assert property ($changed(pin_out) && $stable(array_out_sel) && $stable(array_out_val) && $stable(addr_high_byte_sel) |-> $past(psel && penable && pwrite) || ($past(addr_strobe, 2) && !$past(addr_strobe)))
    else $error("pin drive changed with no cause");
  wr_seen_c: cover property (wr_s);
endmodule
bind port_pin_mode_logic ppml_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .addr_strobe, .addr_high_byte_sel, .array_out_sel,
  .array_out_val, .array_oe_term, .pin_in, .pin_out, .pin_oe, .logic_array_in);

// file: testbench/ppml_pins_model.sv
// far-side pin model: outside drivers plus weak pull-ups on every pin
// assumes the block's drive wins wherever its output enable is high
`timescale 1ns/10ps
module ppml_pins_model (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_drive,
  input wire logic [31:0] ext_en,
  output logic [31:0] pin_in
);
  // a released pin floats up, never keeps a stale level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_en) | (~pin_oe & ext_en & ext_drive);
endmodule
